// File: rtl/mpb_ctrl.sv
// External memory and peripheral bus controller with boot vector capture
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Direction output high for reads from, low for writes to, an external device.
// - In wait mode, a low wait input stretches the strobe phase.
// - In acknowledge mode, a low acknowledge input ends the strobe phase.
// - Read strobe only low while the external device is expected to drive data.
// - Data pins bidirectional normally, inputs only while cold reset is held.
// - Transceiver direction output tracks transfer direction for direct connection.
// - Transceiver enable low whenever the transceiver must pass data.
// - Four low-active selects, exactly the addressed one low during a cycle.
// - 22-bit address driven; upper four bits live elsewhere as alternate functions.
// - Low-active write strobe during write transfers.
// - Names ending in _n are active low, everything else active high.
// - Boot vector bit 11 set disables watchdog after cold reset.
module mpb_ctrl
(
   // Clock and resets
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic power_on_reset_n_in,
   // Wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [mpb_pkg::WB_AW-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // External bus
   output logic [mpb_pkg::ADDR_W-1:0] ext_address_out,
   output logic [mpb_pkg::CS_N-1:0] device_selects_n_out,
   output logic read_not_write_out,
   output logic read_strobe_n_out,
   output logic write_enable_n_out,
   output logic xcvr_direction_n_out,
   output logic xcvr_output_enable_n_out,
   input wire logic wait_or_ack_n_in,
   input wire logic [mpb_pkg::DATA_W-1:0] ext_data_in,
   output logic [mpb_pkg::DATA_W-1:0] ext_data_out,
   output logic ext_data_oe_out,
   // Boot configuration
   output logic watchdog_disable_out
);
   import mpb_pkg::*;

   function automatic logic [CS_N-1:0] sel_decode_n(input logic [1:0] idx);
      sel_decode_n = ~(4'h1 << idx);
   endfunction

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   logic rst_w;
   logic wb_req_w;
   logic ack_mode_ff;
   logic [3:0] strb_cyc_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [1:0] cs_idx_ff;
   logic [DATA_W-1:0] wdata_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic rd_ff;
   logic start_ff;
   logic done_ff;
   logic [3:0] cnt_ff;
   logic [BOOT_W-1:0] shadow_ff;
   logic [BOOT_W-1:0] boot_ff;
   logic cold_prev_ff;
   phase_t phase_ff;
   phase_t nxt_phase;
   logic strobe_end_w;

   // Cold reset resets everything except the boot capture logic, which keeps the captured boot vector and the watchdog disable output
   assign rst_w = srst_in | ~power_on_reset_n_in;
   assign wb_req_w = wb_cyc_in & wb_stb_in & ~wb_ack_out;

   // ----------------------------------------
   // Wishbone slave, one wait state
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_w)
      begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_out <= wb_req_w;
         wb_dat_out <= 32'h0000_0000;
         if (wb_req_w && !wb_we_in)
         begin
            unique case (wb_adr_in)
               OFS_CTRL: wb_dat_out <= {24'h00_0000, strb_cyc_ff, 3'h0, ack_mode_ff};
               OFS_ADDR: wb_dat_out <= {6'h00, cs_idx_ff, 2'h0, addr_ff};
               OFS_WDATA: wb_dat_out <= {24'h00_0000, wdata_ff};
               OFS_CMD: wb_dat_out <= {30'h0000_0000, done_ff, phase_ff != PH_IDLE};
               OFS_RDATA: wb_dat_out <= {24'h00_0000, rdata_ff};
               OFS_BOOT: wb_dat_out <= {16'h0000, boot_ff};
               default: wb_dat_out <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_w)
      begin
         ack_mode_ff <= 1'b0;
         strb_cyc_ff <= STRB_CYC_RST;
         addr_ff <= 22'h00_0000;
         cs_idx_ff <= 2'h0;
         wdata_ff <= 8'h00;
      end
      else if (wb_req_w && wb_we_in)
      begin
         if (wb_adr_in == OFS_CTRL && wb_sel_in[0])
         begin
            ack_mode_ff <= wb_dat_in[CTRL_ACK_MODE_BIT];
            strb_cyc_ff <= wb_dat_in[CTRL_STRB_LSB +: 4];
         end
         // Address is not changed under a running cycle
         if (wb_adr_in == OFS_ADDR && phase_ff == PH_IDLE && !start_ff)
         begin
            if (wb_sel_in[0])
               addr_ff[7:0] <= wb_dat_in[7:0];
            if (wb_sel_in[1])
               addr_ff[15:8] <= wb_dat_in[15:8];
            if (wb_sel_in[2])
               addr_ff[21:16] <= wb_dat_in[21:16];
            if (wb_sel_in[3])
               cs_idx_ff <= wb_dat_in[ADDR_CS_LSB +: 2];
         end
         if (wb_adr_in == OFS_WDATA && wb_sel_in[0] && phase_ff == PH_IDLE && !start_ff)
            wdata_ff <= wb_dat_in[7:0];
      end
   end

   // Start is ignored while busy; done is sticky and set wins over clear
   always_ff @(posedge clk_in)
   begin
      if (rst_w)
      begin
         start_ff <= 1'b0;
         rd_ff <= 1'b0;
         done_ff <= 1'b0;
      end
      else
      begin
         start_ff <= 1'b0;
         if (wb_req_w && wb_we_in && wb_adr_in == OFS_CMD && wb_sel_in[0]
            && phase_ff == PH_IDLE && !start_ff && wb_dat_in[CMD_START_BIT])
         begin
            start_ff <= 1'b1;
            rd_ff <= wb_dat_in[CMD_READ_BIT];
         end
         if (phase_ff == PH_HOLD)
            done_ff <= 1'b1;
         else if (wb_req_w && wb_we_in && wb_adr_in == OFS_CMD && wb_sel_in[0]
            && wb_dat_in[STAT_DONE_BIT])
            done_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // External cycle sequencer
   // ----------------------------------------
   always_comb
   begin
      strobe_end_w = 1'b0;
      if (ack_mode_ff)
         strobe_end_w = ~wait_or_ack_n_in;
      else
         strobe_end_w = (cnt_ff <= 4'h1) & wait_or_ack_n_in;
   end

   always_comb
   begin
      nxt_phase = phase_ff;
      unique case (phase_ff)
         PH_IDLE: if (start_ff) nxt_phase = PH_SETUP;
         PH_SETUP: nxt_phase = PH_STROBE;
         PH_STROBE: if (strobe_end_w) nxt_phase = PH_HOLD;
         PH_HOLD: nxt_phase = PH_IDLE;
         default: nxt_phase = PH_IDLE;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_w)
      begin
         phase_ff <= PH_IDLE;
         cnt_ff <= 4'h0;
      end
      else
      begin
         phase_ff <= nxt_phase;
         if (nxt_phase == PH_STROBE && phase_ff != PH_STROBE)
            cnt_ff <= strb_cyc_ff;
         else if (cnt_ff != 4'h0)
            cnt_ff <= cnt_ff - 4'h1;
      end
   end

   // Read data taken on the edge that closes the strobe
   always_ff @(posedge clk_in)
   begin
      if (rst_w)
         rdata_ff <= 8'h00;
      else if (phase_ff == PH_STROBE && strobe_end_w && rd_ff)
         rdata_ff <= ext_data_in;
   end

   // Pin outputs follow the next phase so every pin comes from a flop
   always_ff @(posedge clk_in)
   begin
      if (rst_w)
      begin
         ext_address_out <= 22'h00_0000;
         device_selects_n_out <= 4'hF;
         read_not_write_out <= 1'b1;
         read_strobe_n_out <= 1'b1;
         write_enable_n_out <= 1'b1;
         xcvr_direction_n_out <= 1'b0;
         xcvr_output_enable_n_out <= 1'b1;
         ext_data_out <= 8'h00;
         ext_data_oe_out <= 1'b0;
      end
      else
      begin
         read_strobe_n_out <= ~(nxt_phase == PH_STROBE && rd_ff);
         write_enable_n_out <= ~(nxt_phase == PH_STROBE && !rd_ff);
         if (nxt_phase == PH_IDLE)
         begin
            device_selects_n_out <= 4'hF;
            xcvr_output_enable_n_out <= 1'b1;
            ext_data_oe_out <= 1'b0;
            read_not_write_out <= 1'b1;
            xcvr_direction_n_out <= 1'b0;
         end
         else
         begin
            ext_address_out <= addr_ff;
            device_selects_n_out <= sel_decode_n(cs_idx_ff);
            read_not_write_out <= rd_ff;
            xcvr_direction_n_out <= ~rd_ff;
            xcvr_output_enable_n_out <= 1'b0;
            ext_data_out <= wdata_ff;
            ext_data_oe_out <= ~rd_ff;
         end
      end
   end

   // ----------------------------------------
   // Boot vector capture
   // ----------------------------------------
   // Eight data pins carry sixteen bits: the last two bytes seen before release,
   // high byte first. Reserved bits are stored as given, not forced.
   always_ff @(posedge clk_in)
   begin
      cold_prev_ff <= ~power_on_reset_n_in;
      if (!power_on_reset_n_in)
         shadow_ff <= {shadow_ff[7:0], ext_data_in};
      if (cold_prev_ff && power_on_reset_n_in)
      begin
         boot_ff <= shadow_ff;
         watchdog_disable_out <= shadow_ff[BOOT_WDOG_DIS_BIT];
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_w);

   AST_WRITE_DIR: assert property (!write_enable_n_out |-> !read_not_write_out && ext_data_oe_out)
      else $error("write strobe with read direction");
   AST_READ_OE: assert property (!read_strobe_n_out |-> read_not_write_out && !ext_data_oe_out)
      else $error("read strobe while driving data");
   AST_WAIT_HOLD: assert property (phase_ff == PH_STROBE && !ack_mode_ff && !wait_or_ack_n_in
      |=> phase_ff == PH_STROBE)
      else $error("wait did not stretch cycle");
   AST_ACK_END: assert property (phase_ff == PH_STROBE && ack_mode_ff && !wait_or_ack_n_in
      |=> phase_ff == PH_HOLD ##1 phase_ff == PH_IDLE)
      else $error("ack did not end cycle");
   AST_XCVR_DIR: assert property (!xcvr_output_enable_n_out
      |-> xcvr_direction_n_out == !read_not_write_out)
      else $error("transceiver direction wrong");
   AST_XCVR_EN: assert property ((!read_strobe_n_out || !write_enable_n_out)
      |-> !xcvr_output_enable_n_out)
      else $error("transceiver off during strobe");
   AST_ONE_SEL: assert property ((!read_strobe_n_out || !write_enable_n_out)
      |-> $onehot(~device_selects_n_out) && $stable(ext_address_out))
      else $error("select or address wrong during strobe");
   AST_COLD_IN: assert property (@(posedge clk_in) disable iff (1'b0)
      $past(!power_on_reset_n_in) |-> !ext_data_oe_out)
      else $error("data driven during cold reset");
   AST_WDOG: assert property (@(posedge clk_in) disable iff (1'b0)
      $rose(power_on_reset_n_in)
      |=> watchdog_disable_out == $past(shadow_ff[BOOT_WDOG_DIS_BIT]))
      else $error("watchdog disable not captured");
   AST_BOOT_HOLD: assert property (@(posedge clk_in) disable iff (1'b0)
      power_on_reset_n_in && $past(power_on_reset_n_in) && !$past(cold_prev_ff)
      |-> $stable(boot_ff))
      else $error("boot vector changed");

   COV_READ: cover property (phase_ff == PH_STROBE && rd_ff ##1 phase_ff == PH_HOLD);
   COV_WRITE_WAIT: cover property (!write_enable_n_out && !wait_or_ack_n_in ##1 !write_enable_n_out);
   COV_ACK: cover property (ack_mode_ff && phase_ff == PH_STROBE && !wait_or_ack_n_in);
endmodule

// File: rtl/mpb_pkg.sv
// Constants for the external memory and peripheral bus controller
package mpb_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ADDR_W = 22;
   localparam int DATA_W = 8;
   localparam int CS_N = 4;
   localparam int BOOT_W = 16;
   localparam int WB_AW = 8;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_WDATA = 8'h08;
   localparam logic [7:0] OFS_CMD = 8'h0C;
   localparam logic [7:0] OFS_RDATA = 8'h10;
   localparam logic [7:0] OFS_BOOT = 8'h14;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTRL_ACK_MODE_BIT = 0;
   localparam int CTRL_STRB_LSB = 4;
   localparam int ADDR_CS_LSB = 24;
   localparam int CMD_START_BIT = 0;
   localparam int CMD_READ_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int BOOT_WDOG_DIS_BIT = 11;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [3:0] STRB_CYC_RST = 4'h2;
   localparam logic [15:0] BOOT_RST = 16'h0000;
   // ----------------------------------------
   // Bus cycle phases
   // ----------------------------------------
   typedef enum logic [3:0] {
      PH_IDLE = 4'b0001,
      PH_SETUP = 4'b0010,
      PH_STROBE = 4'b0100,
      PH_HOLD = 4'b1000
   } phase_t;
endpackage

// File: test/memory_peripheral_bus_boot_capture_bench.sv
// Testbench for the external bus controller and boot capture
`timescale 1ns/1ps
module memory_peripheral_bus_boot_capture_bench;
   import mpb_pkg::*;
   logic clk_in = 1'b0, srst_in = 1'b1, por_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic ack_mode = 1'b0, rnw, rs_n, we_n, dir_n, boe_n, wait_n, doe, wdog, wb_ack;
   logic [3:0] sel = 4'hF, dly = 4'h0, cs_n;
   logic [WB_AW-1:0] adr = '0;
   logic [31:0] wdat = '0, wb_dat, q;
   logic [ADDR_W-1:0] ext_addr, s_addr;
   logic [7:0] boot_byte = 8'h00, din, dout, wbyte, snap;
   int mismatches = 0, checks = 0, rd_cnt = 0, wr_cnt = 0;
   initial forever #5 clk_in = ~clk_in;
   mpb_ctrl mpb_ctrl_i (.clk_in(clk_in), .srst_in(srst_in), .power_on_reset_n_in(por_n),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(wb_dat), .wb_ack_out(wb_ack), .ext_address_out(ext_addr),
      .device_selects_n_out(cs_n), .read_not_write_out(rnw), .read_strobe_n_out(rs_n),
      .write_enable_n_out(we_n), .xcvr_direction_n_out(dir_n), .xcvr_output_enable_n_out(boe_n),
      .wait_or_ack_n_in(wait_n), .ext_data_in(din), .ext_data_out(dout), .ext_data_oe_out(doe),
      .watchdog_disable_out(wdog));
   mpb_ext_model mpb_ext_model_i (.clk_in(clk_in), .power_on_reset_n_in(por_n),
      .ack_mode_in(ack_mode), .delay_in(dly), .boot_byte_in(boot_byte), .ext_address_in(ext_addr),
      .read_strobe_n_in(rs_n), .write_enable_n_in(we_n), .ctrl_data_in(dout),
      .ctrl_data_oe_in(doe), .wait_or_ack_n_out(wait_n), .bus_data_out(din),
      .written_byte_out(wbyte));
   // ----------------------------------------
   // Strobe monitor
   // ----------------------------------------
   always @(posedge clk_in)
   begin
      rd_cnt += (rs_n === 1'b0);
      wr_cnt += (we_n === 1'b0);
      if (rs_n === 1'b0 || we_n === 1'b0)
      begin
         snap = {cs_n, rnw, dir_n, boe_n, doe};
         s_addr = ext_addr;
      end
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic stop_test();
      $display("counts: checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask
   // Classic cycle: hold everything until ack is sampled, then release
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_in);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (wb_ack !== 1'b1)
      begin
         $display("ERROR wb_ack expected 1 seen %b", wb_ack);
         mismatches++;
         stop_test();
      end
      q = wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic xfer(input logic [31:0] ctrl, input logic [31:0] a, input logic [31:0] cmd);
      int n;
      n = 0;
      wb(1'b1, OFS_CTRL, ctrl);
      wb(1'b1, OFS_ADDR, a);
      rd_cnt = 0;
      wr_cnt = 0;
      wb(1'b1, OFS_CMD, cmd);
      do
      begin
         wb(1'b0, OFS_CMD, 32'h0);
         n++;
      end while (q[STAT_DONE_BIT] !== 1'b1 && n < 50);
      if (q[STAT_DONE_BIT] !== 1'b1)
      begin
         $display("ERROR done expected 1 seen %b", q[STAT_DONE_BIT]);
         mismatches++;
         stop_test();
      end
      chk("status", 32'h2, q);
      chk("idle_pins", 7'h7F, {cs_n, rs_n, we_n, rnw});
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic boot_test(input logic [7:0] hi, input logic [7:0] lo);
      por_n <= 1'b0;
      boot_byte <= hi;
      repeat (7) @(posedge clk_in);
      boot_byte <= lo;
      @(posedge clk_in);
      por_n <= 1'b1;
      srst_in <= 1'b0;
      wb(1'b0, OFS_BOOT, 32'h0);
      chk("boot_vector", {hi, lo}, q);
      chk("watchdog_disable", hi[3], wdog);
      $display("test boot done");
   endtask
   task automatic warm_test();
      @(posedge clk_in);
      srst_in <= 1'b1;
      @(posedge clk_in);
      srst_in <= 1'b0;
      wb(1'b0, OFS_BOOT, 32'h0);
      chk("boot_after_warm", 32'h00C5, q);
      chk("wdog_after_warm", 32'h0, wdog);
      $display("test warm reset done");
   endtask
   task automatic write_test();
      // Wait held low through the two counted strobe cycles, stretching the strobe by one
      dly <= 4'h2;
      wb(1'b1, OFS_WDATA, 32'hC3);
      wb(1'b0, OFS_WDATA, 32'h0);
      chk("wdata_reg", 32'hC3, q);
      xfer(32'h20, 32'h022ABCD5, 32'h1);
      chk("write_strobes", 3, wr_cnt);
      chk("read_strobes", 0, rd_cnt);
      chk("pins", 8'hB5, snap);
      chk("address", 22'h2ABCD5, s_addr);
      chk("written", 8'hC3, wbyte);
      wb(1'b0, OFS_ADDR, 32'h0);
      chk("addr_reg", 32'h022ABCD5, q);
      // Only the low byte lane is enabled, so the upper lanes keep their value
      sel <= 4'h1;
      wb(1'b1, OFS_ADDR, 32'hFFFF_FFFF);
      sel <= 4'hF;
      wb(1'b0, OFS_ADDR, 32'h0);
      chk("addr_sel", 32'h022ABCFF, q);
      $display("test write done");
   endtask
   task automatic read_test(input logic m, input logic [3:0] d, input logic [31:0] a,
                            input int strobes, input logic [7:0] pins);
      @(posedge clk_in);
      ack_mode <= m;
      dly <= d;
      xfer({28'h2, 3'h0, m}, a, 32'h3);
      wb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl_reg", {28'h2, 3'h0, m}, q);
      chk("read_strobes", strobes, rd_cnt);
      chk("write_strobes", 0, wr_cnt);
      chk("pins", pins, snap);
      chk("address", a[21:0], s_addr);
      wb(1'b0, OFS_RDATA, 32'h0);
      chk("read_data", a[7:0] ^ 8'h5A, q);
      wb(1'b0, 8'h1C, 32'h0);
      chk("unmapped", 32'h0, q);
      $display("test read done");
   endtask
   initial
   begin
      boot_test(8'h08, 8'h3C);
      boot_test(8'h00, 8'hC5);
      warm_test();
      write_test();
      read_test(1'b0, 4'h4, 32'h01000155, 5, 8'hD8);
      read_test(1'b1, 4'h3, 32'h033FFFFF, 4, 8'h78);
      stop_test();
   end
endmodule

// File: test/mpb_ext_model.sv
// Partner model: external byte device with wait or acknowledge, and boot source
`timescale 1ns/1ps
module mpb_ext_model
(
   // Clock and cold reset
   input wire logic clk_in,
   input wire logic power_on_reset_n_in,
   // Bench controls
   input wire logic ack_mode_in,
   input wire logic [3:0] delay_in,
   input wire logic [7:0] boot_byte_in,
   // From the controller
   input wire logic [mpb_pkg::ADDR_W-1:0] ext_address_in,
   input wire logic read_strobe_n_in,
   input wire logic write_enable_n_in,
   input wire logic [mpb_pkg::DATA_W-1:0] ctrl_data_in,
   input wire logic ctrl_data_oe_in,
   // To the controller and the bench
   output logic wait_or_ack_n_out,
   output logic [mpb_pkg::DATA_W-1:0] bus_data_out,
   output logic [mpb_pkg::DATA_W-1:0] written_byte_out
);
   import mpb_pkg::*;
   logic [3:0] strobe_cnt_ff;
   logic [7:0] last_ff;
   logic strobing;
   // ----------------------------------------
   // Handshake
   // ----------------------------------------
   assign strobing = !read_strobe_n_in || !write_enable_n_in;
   always_ff @(posedge clk_in) strobe_cnt_ff <= strobing ? strobe_cnt_ff + 4'h1 : 4'h0;
   // Wait is low for the first delay cycles, acknowledge comes after them
   assign wait_or_ack_n_out = !(strobing && (ack_mode_in ? strobe_cnt_ff >= delay_in
                                                         : strobe_cnt_ff < delay_in));
   // ----------------------------------------
   // Data bus
   // ----------------------------------------
   // Released bus toggles, so a stale byte never looks valid
   assign bus_data_out = ctrl_data_oe_in ? ctrl_data_in
                       : !power_on_reset_n_in ? boot_byte_in
                       : !read_strobe_n_in ? ext_address_in[7:0] ^ 8'h5A : ~last_ff;
   always_ff @(posedge clk_in) last_ff <= bus_data_out;
   always_ff @(posedge clk_in)
      if (!write_enable_n_in && ctrl_data_oe_in)
         written_byte_out <= ctrl_data_in;
endmodule
